/* verilog/ehm_monitor.sv */
// Purpose: error-rate health monitor with timed off-line measure and save
// Assumes: operation reports and commands arrive on ref_clk; bus_idle is a pin
// Notes: the pending code lives in an external non-volatile store
// Behaviour
// - monitor-disable suspends all monitoring and reporting
// - collect statistics on each read or write
// - online-only never starts off-line measurement
// - rezero command forces immediate measurement
// - forced measurement reloads two-hour timer
// - log page read returns time remaining
// - measure and save every two hours when idle
// - measurement uninterruptible, bounded 60 or 370 ms
// - predictive failure reports sense code
// - pending code survives resets and power cycles
// - interval counter counts operations per attribute
// - failure counter counts errors in interval
// - threshold exceeded early means unacceptable interval
// - interval complete under threshold means acceptable
// - both counters cleared after classification
// - history counter up bad, down good, floor zero
// - history at threshold signals predictive failure
module ehm_monitor #(
   parameter int N_ATTR = 4,
   parameter longint unsigned MEAS_PERIOD = ehm_pkg::MEAS_PERIOD_CYC,
   parameter int unsigned ONLINE_DELAY = ehm_pkg::ONLINE_DELAY_CYC,
   parameter int unsigned FULL_DELAY = ehm_pkg::FULL_DELAY_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire ehm_pkg::ehm_mode_type mode,
   input wire ehm_pkg::ehm_op_type op,
   input wire logic bus_idle,
   input wire logic rezero_cmd,
   input wire logic log_read,
   input wire logic [7:0] log_page,
   input wire logic [ehm_pkg::CNT_W-1:0] interval_len,
   input wire logic [ehm_pkg::CNT_W-1:0] err_thresh,
   input wire logic [ehm_pkg::HIST_W-1:0] hist_thresh,
   input wire logic nv_pending,
   input wire logic sense_ack,
   output logic log_valid,
   output logic [ehm_pkg::TIMER_W-1:0] log_data,
   output logic meas_busy,
   output ehm_pkg::ehm_sense_type sense,
   output logic nv_write,
   output logic nv_value
);
   import ehm_pkg::*;

   localparam logic [TIMER_W-1:0] PERIOD = TIMER_W'(MEAS_PERIOD);
   localparam logic [TIMER_W-1:0] ONLINE_LEN = TIMER_W'(ONLINE_DELAY);
   localparam logic [TIMER_W-1:0] FULL_LEN = TIMER_W'(FULL_DELAY);

   logic idle_s1_q, idle_s2_q, nvp_s1_q, nvp_s2_q;
   logic [N_ATTR-1:0] attr_predict;
   logic any_predict;
   ehm_state_type state_q, state_d;
   logic [TIMER_W-1:0] timer_q, timer_d;
   logic [TIMER_W-1:0] work_q, work_d;
   logic pend_q, pend_d;
   logic meas_busy_d;
   logic log_valid_d;
   logic [TIMER_W-1:0] log_data_d;
   ehm_sense_type sense_d;
   logic nv_write_d, nv_value_d;
   logic reported_q, reported_d;
   logic loaded_q, loaded_d;
   logic boot_s1_q, boot_s2_q;

   // pin synchronisers for bus idle and stored pending code
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         idle_s1_q <= 1'b0;
         idle_s2_q <= 1'b0;
         nvp_s1_q <= 1'b0;
         nvp_s2_q <= 1'b0;
         boot_s1_q <= 1'b0;
         boot_s2_q <= 1'b0;
      end else begin
         idle_s1_q <= bus_idle;
         idle_s2_q <= idle_s1_q;
         nvp_s1_q <= nv_pending;
         nvp_s2_q <= nvp_s1_q;
         // marks when the stored code has crossed the synchroniser
         boot_s1_q <= 1'b1;
         boot_s2_q <= boot_s1_q;
      end
   end

   // per-attribute rate counting
   genvar g;
   generate
      for (g = 0; g < N_ATTR; g++) begin : g_attr
         ehm_attr #(.CNT_W(CNT_W), .HIST_W(HIST_W)) u_attr (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .enable(!mode.monitor_disable),
            .op_valid(op.valid && (op.attr == 2'(g))),
            .op_error(op.error),
            .interval_len(interval_len),
            .err_thresh(err_thresh),
            .hist_thresh(hist_thresh),
            .predict(attr_predict[g])
         );
      end
   endgenerate

   assign any_predict = |attr_predict;

   // measurement scheduler and timer
   always_comb begin
      state_d = state_q;
      timer_d = timer_q;
      work_d = work_q;
      pend_d = pend_q;
      meas_busy_d = 1'b0;
      unique case (state_q)
         EHM_IDLE: begin
            if (timer_q != '0) begin
               timer_d = timer_q - TIMER_W'(1);
            end else begin
               pend_d = 1'b1;
            end
            if (rezero_cmd) begin
               pend_d = 1'b1;
               timer_d = PERIOD;
            end
            if (mode.monitor_disable) begin
               pend_d = 1'b0;
            end else if ((pend_q || rezero_cmd) && (idle_s2_q || rezero_cmd)) begin
               state_d = EHM_MEASURE;
               pend_d = 1'b0;
               meas_busy_d = 1'b1;
               if (!rezero_cmd) begin
                  timer_d = PERIOD;
               end
               // online-only does only the short save, no off-line pass
               work_d = mode.online_only_select ? ONLINE_LEN - TIMER_W'(1) : FULL_LEN - TIMER_W'(1);
            end
         end
         EHM_MEASURE: begin
            meas_busy_d = 1'b1;
            if (timer_q != '0) begin
               timer_d = timer_q - TIMER_W'(1);
            end
            if (rezero_cmd) begin
               timer_d = PERIOD;
            end
            if (work_q == '0) begin
               state_d = EHM_IDLE;
               meas_busy_d = 1'b0;
            end else begin
               work_d = work_q - TIMER_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= EHM_IDLE;
         timer_q <= PERIOD;
         work_q <= '0;
         pend_q <= 1'b0;
         meas_busy <= 1'b0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         work_q <= work_d;
         pend_q <= pend_d;
         meas_busy <= meas_busy_d;
      end
   end

   // log page answer and failure reporting
   always_comb begin
      log_valid_d = 1'b0;
      log_data_d = '0;
      sense_d = sense;
      nv_write_d = 1'b0;
      nv_value_d = nv_value;
      reported_d = reported_q;
      loaded_d = boot_s2_q;
      if (log_read && log_page == TIMER_LOG_PAGE) begin
         log_valid_d = 1'b1;
         log_data_d = timer_q;
      end
      if (!loaded_q && boot_s2_q && nvp_s2_q) begin
         reported_d = 1'b1;
      end
      if (any_predict && !reported_q && !mode.monitor_disable) begin
         reported_d = 1'b1;
         nv_write_d = 1'b1;
         nv_value_d = 1'b1;
      end
      if (sense_ack) begin
         sense_d.valid = 1'b0;
      end
      if (reported_q && !mode.monitor_disable && !sense.valid && !sense_ack) begin
         sense_d.valid = 1'b1;
         sense_d.key = SENSE_KEY_RECOVERED;
         sense_d.asc = SENSE_ASC_PREDICT;
         sense_d.ascq = SENSE_ASCQ_PREDICT;
      end
      if (mode.monitor_disable) begin
         sense_d.valid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         log_valid <= 1'b0;
         log_data <= '0;
         sense <= '0;
         nv_write <= 1'b0;
         nv_value <= 1'b0;
         reported_q <= 1'b0;
         loaded_q <= 1'b0;
      end else begin
         log_valid <= log_valid_d;
         log_data <= log_data_d;
         sense <= sense_d;
         nv_write <= nv_write_d;
         nv_value <= nv_value_d;
         reported_q <= reported_d;
         loaded_q <= loaded_d;
      end
   end
endmodule : ehm_monitor

/* verilog/ehm_pkg.sv */
// Purpose: shared types and constants for the error-rate health monitor
// Assumes: 100 MHz ref_clk
// Notes: timing counts derive from printed times and the clock rate
package ehm_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned MEAS_PERIOD_S = 7200; // two hours
   localparam longint unsigned MEAS_PERIOD_CYC = longint'(MEAS_PERIOD_S) * longint'(CLK_HZ);
   localparam int unsigned ONLINE_DELAY_MS = 60;
   localparam int unsigned FULL_DELAY_MS = 370;
   localparam int unsigned ONLINE_DELAY_CYC = ONLINE_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned FULL_DELAY_CYC = FULL_DELAY_MS * (CLK_HZ / 1000);
   localparam int TIMER_W = 40;
   localparam int CNT_W = 16;
   localparam int HIST_W = 8;
   localparam logic [7:0] TIMER_LOG_PAGE = 8'h3e;
   localparam logic [3:0] SENSE_KEY_RECOVERED = 4'h1;
   localparam logic [7:0] SENSE_ASC_PREDICT = 8'h5d;
   localparam logic [7:0] SENSE_ASCQ_PREDICT = 8'h00;

   // mode bits as held in the control page
   typedef struct packed {
      logic monitor_disable;
      logic online_only_select;
   } ehm_mode_type;

   // one operation report from the read/write path
   typedef struct packed {
      logic valid;
      logic [1:0] attr;
      logic error;
   } ehm_op_type;

   // failure-prediction sense data
   typedef struct packed {
      logic valid;
      logic [3:0] key;
      logic [7:0] asc;
      logic [7:0] ascq;
   } ehm_sense_type;

   typedef enum logic [1:0] {
      EHM_IDLE,
      EHM_MEASURE
   } ehm_state_type;
endpackage : ehm_pkg

/* verilog/ehm_attr.sv */
// Purpose: interval, failure and history counting for one attribute
// Assumes: op strobes come from logic on ref_clk
// Notes: predict stays high while history sits at the threshold or above
module ehm_attr #(
   parameter int CNT_W = 16,
   parameter int HIST_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic op_valid,
   input wire logic op_error,
   input wire logic [CNT_W-1:0] interval_len,
   input wire logic [CNT_W-1:0] err_thresh,
   input wire logic [HIST_W-1:0] hist_thresh,
   output logic predict
);
   import ehm_pkg::*;

   logic [CNT_W-1:0] intv_q, intv_d;
   logic [CNT_W-1:0] fail_q, fail_d;
   logic [HIST_W-1:0] hist_q, hist_d;
   logic [CNT_W-1:0] fail_inc;
   logic [CNT_W-1:0] intv_inc;

   // counting and interval classification
   always_comb begin
      intv_d = intv_q;
      fail_d = fail_q;
      hist_d = hist_q;
      fail_inc = fail_q + CNT_W'(op_error);
      intv_inc = intv_q + CNT_W'(1);
      if (enable && op_valid) begin
         if (fail_inc > err_thresh) begin
            // too many errors before the interval ended
            intv_d = '0;
            fail_d = '0;
            if (hist_q != '1) begin
               hist_d = hist_q + HIST_W'(1);
            end
         end else if (intv_inc >= interval_len) begin
            intv_d = '0;
            fail_d = '0;
            if (hist_q != '0) begin
               hist_d = hist_q - HIST_W'(1);
            end
         end else begin
            intv_d = intv_inc;
            fail_d = fail_inc;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         intv_q <= '0;
         fail_q <= '0;
         hist_q <= '0;
      end else begin
         intv_q <= intv_d;
         fail_q <= fail_d;
         hist_q <= hist_d;
      end
   end

   assign predict = (hist_q >= hist_thresh);
endmodule : ehm_attr

/* tb/ehm_monitor_sva.sv */
// Purpose: port checks for the health monitor
// Assumes: one clock, synchronous active-low reset
// Notes: delays come from the bound instance
module ehm_monitor_sva import ehm_pkg::*; #(
   parameter longint unsigned MEAS_PERIOD = 1000,
   parameter int unsigned ONLINE_DELAY = 5,
   parameter int unsigned FULL_DELAY = 9
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire ehm_pkg::ehm_mode_type mode,
   input wire logic rezero_cmd,
   input wire logic log_read,
   input wire logic [7:0] log_page,
   input wire logic log_valid,
   input wire logic [ehm_pkg::TIMER_W-1:0] log_data,
   input wire logic meas_busy,
   input wire ehm_pkg::ehm_sense_type sense
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   logic [15:0] run_q;
   logic [15:0] run_d;
   // length of the running measurement
   always_comb begin
      run_d = meas_busy ? run_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge ref_clk) begin
      run_q <= rst_n ? run_d : 16'h0000;
   end
   // request steps
   sequence s_log_req;
      log_read && log_page == TIMER_LOG_PAGE;
   endsequence
   sequence s_force;
      rezero_cmd && !meas_busy && !mode.monitor_disable;
   endsequence
   a_log_answer: assert property (s_log_req |=> log_valid)
      else $error("log read unanswered");
   a_log_refuse: assert property (!(log_read && log_page == TIMER_LOG_PAGE) |=> !log_valid)
      else $error("log answer without request");
   a_log_bound: assert property (log_valid |-> log_data <= MEAS_PERIOD)
      else $error("time left beyond period");
   a_force_start: assert property (s_force |=> meas_busy)
      else $error("forced measure not started");
   a_run_length: assert property ($fell(meas_busy) |->
      run_q == (mode.online_only_select ? ONLINE_DELAY : FULL_DELAY)) else $error("measure length wrong");
   a_quiet_off: assert property (mode.monitor_disable && !meas_busy |=> !meas_busy)
      else $error("measure while disabled");
   a_quiet_sense: assert property (mode.monitor_disable [*2] |-> !sense.valid)
      else $error("report while disabled");
   a_sense_code: assert property (sense.valid |-> sense.key == SENSE_KEY_RECOVERED &&
      sense.asc == SENSE_ASC_PREDICT && sense.ascq == SENSE_ASCQ_PREDICT) else $error("bad sense code");
endmodule : ehm_monitor_sva

bind ehm_monitor ehm_monitor_sva #(.MEAS_PERIOD(MEAS_PERIOD), .ONLINE_DELAY(ONLINE_DELAY),
   .FULL_DELAY(FULL_DELAY)) u_sva (.ref_clk, .rst_n, .mode, .rezero_cmd, .log_read, .log_page,
   .log_valid, .log_data, .meas_busy, .sense);

/* tb/ehm_host_model.sv */
// Purpose: host adapter model at the monitor's bus side
// Assumes: ref_clk domain, outputs change after the rising edge
// Notes: quiet asks for a quiesced bus, ack_dly sets sense handling speed
module ehm_host_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic quiet,
   input wire logic [3:0] ack_dly,
   input wire logic sense_valid,
   output logic bus_idle = 1'b0,
   output logic sense_ack = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q = 4'h0;
   // bus idle follows quiet one edge later, held low in reset; sense consumed after ack_dly
   always @(posedge ref_clk) begin
      bus_idle <= rst_n && quiet;
      sense_ack <= 1'b0;
      if (!sense_valid || sense_ack) begin
         wait_q <= 4'h0;
      end else if (wait_q == ack_dly) begin
         sense_ack <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule : ehm_host_model

/* tb/ehm_monitor_tb_top.sv */
// Purpose: self-checking bench for the health monitor
// Assumes: shortened timer and measurement delays
// Notes: log and sense results are matched against queued notes
module ehm_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ehm_pkg::*;
   localparam int MEAS_P = 1000;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic quiet = 1'b0;
   logic rezero_cmd = 1'b0;
   logic log_read = 1'b0;
   logic [7:0] log_page = 8'h00;
   logic [3:0] ack_dly = 4'h0;
   logic log_valid, meas_busy, bus_idle, sense_ack, sv_q;
   logic nv_write, nv_value;
   logic nv_store = 1'b0;
   logic [TIMER_W-1:0] log_data;
   ehm_mode_type mode = '0;
   ehm_op_type op = '0;
   ehm_sense_type sense;
   ehm_sense_type sense_exp = '0;
   ehm_sense_type sense_q[$];
   longint log_q[$];
   logic [31:0] rng = 32'hc75d;
   logic [1:0] attr;
   int cyc = 0;
   int ref_cyc = 0;
   int fails = 0;
   int tests_run = 0;
   // clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   ehm_monitor #(.MEAS_PERIOD(MEAS_P), .ONLINE_DELAY(5), .FULL_DELAY(9)) u_dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .mode(mode), .op(op), .bus_idle(bus_idle), .rezero_cmd(rezero_cmd),
      .log_read(log_read), .log_page(log_page), .interval_len(16'h0004), .err_thresh(16'h0001),
      .hist_thresh(8'h02), .nv_pending(nv_store), .sense_ack(sense_ack), .log_valid(log_valid),
      .log_data(log_data), .meas_busy(meas_busy), .sense(sense), .nv_write(nv_write), .nv_value(nv_value));
   // non-volatile store: keeps the pending code across resets
   always @(posedge ref_clk) begin
      if (nv_write === 1'b1) nv_store <= nv_value;
   end
   ehm_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n), .quiet(quiet), .ack_dly(ack_dly),
      .sense_valid(sense.valid), .bus_idle(bus_idle), .sense_ack(sense_ack));
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   task automatic tally(input logic ok, input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (ok !== 1'b1) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : tally
   task automatic check_log(input logic [TIMER_W-1:0] got, input longint exp);
      tally(longint'(got) + 16 >= exp && longint'(got) <= exp + 16, 64'(got), 64'(exp));
   endtask : check_log
   task automatic check_sense(input ehm_sense_type got, input ehm_sense_type exp);
      tally(got === exp, 64'(got), 64'(exp));
   endtask : check_sense
   task automatic check_bit(input logic got, input logic exp);
      @(negedge ref_clk);
      tally(got === exp, 64'(got), 64'(exp));
      @(posedge ref_clk);
   endtask : check_bit
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic interval(input logic bad);
      repeat (bad ? 2 : 4) begin
         @(posedge ref_clk);
         op <= '{valid: 1'b1, attr: attr, error: bad};
         @(posedge ref_clk);
         op <= '0;
      end
   endtask : interval
   task automatic log_req(input logic [7:0] pg);
      @(posedge ref_clk);
      log_read <= 1'b1;
      log_page <= pg;
      if (pg == TIMER_LOG_PAGE) log_q.push_back(MEAS_P - (cyc - ref_cyc));
      @(posedge ref_clk);
      log_read <= 1'b0;
   endtask : log_req
   task automatic rezero();
      @(posedge ref_clk);
      rezero_cmd <= 1'b1;
      @(posedge ref_clk);
      rezero_cmd <= 1'b0;
      ref_cyc = cyc;
   endtask : rezero
   task automatic wait_busy(input logic v);
      for (int n = 0; n < 40 && meas_busy !== v; n++) @(negedge ref_clk);
      check_bit(meas_busy, v);
   endtask : wait_busy
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   // match outputs against the oldest note
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      sv_q <= sense.valid;
      if (log_valid === 1'b1) check_log(log_data, log_q.size() > 0 ? log_q.pop_front() : -64);
      if (sense.valid === 1'b1 && sv_q !== 1'b1) begin
         if (sense_q.size() > 0) sense_exp = sense_q.pop_front();
         check_sense(sense, sense_exp);
      end
   end
   // cut a hang short
   initial begin
      #100us;
      fails++;
      report_and_stop();
   end
   // main sequence
   initial begin
      tick(8);
      rst_n <= 1'b1;
      ref_cyc = cyc;
      log_req(TIMER_LOG_PAGE);
      repeat (4) log_req(8'(xs()));
      $display("test log_read done");
      tick(MEAS_P + 20);
      check_bit(meas_busy, 1'b0);
      quiet <= 1'b1;
      wait_busy(1'b1);
      wait_busy(1'b0);
      quiet <= 1'b0;
      $display("test timed_measure done");
      rezero();
      wait_busy(1'b1);
      wait_busy(1'b0);
      log_req(TIMER_LOG_PAGE);
      mode <= '{monitor_disable: 1'b0, online_only_select: 1'b1};
      rezero();
      rezero();
      wait_busy(1'b0);
      log_req(TIMER_LOG_PAGE);
      $display("test forced_measure done");
      mode <= '{monitor_disable: 1'b1, online_only_select: 1'b0};
      attr = 2'(xs());
      rezero();
      repeat (2) interval(1'b1);
      check_bit(meas_busy, 1'b0);
      mode <= '0;
      interval(1'b1);
      interval(1'b0);
      interval(1'b1);
      tick(4);
      check_bit(sense.valid, 1'b0);
      sense_q.push_back('{valid: 1'b1, key: SENSE_KEY_RECOVERED, asc: SENSE_ASC_PREDICT, ascq: SENSE_ASCQ_PREDICT});
      ack_dly <= 4'(xs()) | 4'h8;
      interval(1'b1);
      tick(4);
      check_bit(sense.valid, 1'b1);
      check_bit(nv_store, 1'b1);
      tick(40);
      mode <= '{monitor_disable: 1'b1, online_only_select: 1'b0};
      tick(4);
      check_bit(sense.valid, 1'b0);
      $display("test error_rate done");
      // bus reset after insertion; stored code must come back
      sense_q.push_back('{valid: 1'b1, key: SENSE_KEY_RECOVERED, asc: SENSE_ASC_PREDICT, ascq: SENSE_ASCQ_PREDICT});
      mode <= '0;
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      tick(6);
      check_bit(sense.valid, 1'b1);
      $display("test nv_restore done");
      report_and_stop();
   end
endmodule : ehm_monitor_tb_top
